// ==== logic/rsc_consts.vh ====
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH
// register byte offsets
`define RSC_ADDR_CAUSE 12'h000
`define RSC_ADDR_STATUS 12'h004
`define RSC_ADDR_CLOCK 12'h008
// cause register field positions
`define RSC_BIT_TRAP 15
`define RSC_BIT_ILLOP 14
`define RSC_BIT_CFGMM 9
`define RSC_BIT_FLASHSLP 8
`define RSC_BIT_PIN 7
`define RSC_BIT_SOFT 6
`define RSC_BIT_SOFT_WATCHDOG_ENABLE 5
`define RSC_BIT_WATCHDOG_TIMEOUT_FLAG 4
`define RSC_BIT_SLEEP 3
`define RSC_BIT_IDLE 2
`define RSC_BIT_BOR 1
`define RSC_BIT_POR 0
// implemented bits of the cause register
`define RSC_CAUSE_MASK 16'hc3ff
// cause value after power-on
`define RSC_CAUSE_POR_VAL 16'h0003
// release delays in ns, and cycles at 4 ns
`define RSC_CLK_NS 4
`define RSC_TPOR_NS 2000
`define RSC_TPWRT_NS 64000000
`define RSC_TRST_NS 40
`define RSC_TPOR_CYC (`RSC_TPOR_NS / `RSC_CLK_NS)
`define RSC_TPWRT_CYC (`RSC_TPWRT_NS / `RSC_CLK_NS)
`define RSC_TRST_CYC (`RSC_TRST_NS / `RSC_CLK_NS)
`endif

// ==== logic/rsc_delay_counter.v ====
`default_nettype none
// down counter that reports done once a loaded count has elapsed
module rsc_delay_counter #(
	parameter WIDTH = 32
) (
	// clock
	input wire i_clock,
	// control
	input wire i_load,
	input wire [WIDTH-1:0] i_count,
	// status
	output reg o_done
);
	reg [WIDTH-1:0] count_q;
	always @(posedge i_clock) begin
		if (i_load) begin
			count_q <= i_count;
			o_done <= 1'b0;
		end else if (count_q != {WIDTH{1'b0}}) begin
			count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== logic/rsc_reset_source_combiner.v ====
// What this block does
// - merge all nine reset sources into one
// - any active source asserts system reset
// - each reset sets a cause bit
// - power-on clears causes, sets bor and por
// - software reads and writes cause bits freely
// - illegal opcode or pointer sets bit fourteen
// - config mismatch sets bit nine
// - bit eight keeps flash bias in sleep
// - reset instruction sets bit six
// - bit five enables watchdog unless fuse forces
// - watchdog timeout flag, cleared by sleep, idle or clear
// - sleep and idle entry set bits three, two
// - por/bor load fuse clock, others keep current
// - no switching: always fuse clock
// - system reset clears core and peripheral state
// - power-on release only after power-on and power-up delays
//
// The register addresses and the APB interface to the registers were left to the implementer.
`default_nettype none
`include "rsc_consts.vh"
module rsc_reset_source_combiner #(
	parameter TPOR_CYCLES = `RSC_TPOR_CYC,
	parameter TPWRT_CYCLES = `RSC_TPWRT_CYC,
	parameter TRST_CYCLES = `RSC_TRST_CYC
) (
	// clock and power-on (i_rst is the power-on source)
	input wire i_clock,
	input wire i_rst,
	// reset requesters, active high
	input wire i_brown_out_reset,
	input wire i_master_clear_pin,
	input wire i_reset_instruction,
	input wire i_watchdog_timeout,
	input wire i_config_mismatch,
	input wire i_trap_conflict,
	input wire i_illegal_opcode,
	input wire i_uninit_pointer_reset,
	// power-save and watchdog instruction events
	input wire i_power_save_sleep,
	input wire i_power_save_idle,
	input wire i_watchdog_clear_instruction,
	// configuration fuses and oscillator state
	input wire i_watchdog_fuse_enable,
	input wire i_clock_switch_enable,
	input wire [2:0] i_initial_oscillator_select,
	input wire [2:0] i_current_oscillator_select,
	// apb slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	// outputs to core and peripherals
	output reg o_master_system_reset,
	output reg o_watchdog_enable,
	output reg o_flash_sleep_power,
	output reg [2:0] o_reset_oscillator_select
);
	localparam ST_POR = 2'b00;
	localparam ST_POWER_UP_TIMER = 2'b01;
	localparam ST_RST = 2'b10;
	localparam ST_RUN = 2'b11;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [15:0] cause_q;
	reg [15:0] cause_d;
	reg bor_seen_q;
	reg load;
	reg [31:0] load_count;
	wire delay_done;
	wire any_source;
	wire wr_cause;
	wire rd_en;
	wire [15:0] wdata;

	function addr_hit;
		input [11:0] addr;
		input [11:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	// non-power-on sources; power-on itself is i_rst
	assign any_source = i_brown_out_reset | i_master_clear_pin | i_reset_instruction |
		i_watchdog_timeout | i_config_mismatch | i_trap_conflict |
		i_illegal_opcode | i_uninit_pointer_reset;
	assign wr_cause = i_psel & i_penable & i_pwrite & addr_hit(i_paddr, `RSC_ADDR_CAUSE);
	assign rd_en = i_psel & ~i_penable & ~i_pwrite;
	assign wdata = i_pwdata[15:0];

	rsc_delay_counter #(
		.WIDTH(32)
	) u_delay (
		.i_clock(i_clock),
		.i_load(load),
		.i_count(load_count),
		.o_done(delay_done)
	);

	// sequencing: power-on, power-up timer, state reset timer, run
	always @* begin
		state_d = state_q;
		load = 1'b0;
		load_count = 32'h0;
		case (state_q)
			ST_POR: begin
				if (delay_done) begin
					state_d = ST_POWER_UP_TIMER;
					load = 1'b1;
					load_count = TPWRT_CYCLES;
				end
			end
			ST_POWER_UP_TIMER: begin
				if (i_brown_out_reset) begin
					// a fresh brown-out restarts the power-up timer
					load = 1'b1;
					load_count = TPWRT_CYCLES;
				end else if (delay_done) begin
					state_d = ST_RST;
					load = 1'b1;
					load_count = TRST_CYCLES;
				end
			end
			ST_RST: begin
				if (i_brown_out_reset) begin
					// brown-out during a short reset still owes the power-up delay
					state_d = ST_POWER_UP_TIMER;
					load = 1'b1;
					load_count = TPWRT_CYCLES;
				end else if (any_source) begin
					load = 1'b1;
					load_count = TRST_CYCLES;
				end else if (delay_done) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (i_brown_out_reset) begin
					state_d = ST_POWER_UP_TIMER;
					load = 1'b1;
					load_count = TPWRT_CYCLES;
				end else if (any_source) begin
					state_d = ST_RST;
					load = 1'b1;
					load_count = TRST_CYCLES;
				end
			end
			default: begin
				state_d = ST_POR;
			end
		endcase
		if (i_rst) begin
			load = 1'b1;
			load_count = TPOR_CYCLES;
		end
	end

	// cause register: hardware sets win over software writes
	always @* begin
		cause_d = cause_q;
		if (wr_cause) begin
			cause_d = wdata & `RSC_CAUSE_MASK;
		end
		if (i_watchdog_clear_instruction | i_power_save_sleep | i_power_save_idle) begin
			cause_d[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
		end
		if (i_trap_conflict) begin
			cause_d[`RSC_BIT_TRAP] = 1'b1;
		end
		if (i_illegal_opcode | i_uninit_pointer_reset) begin
			cause_d[`RSC_BIT_ILLOP] = 1'b1;
		end
		if (i_config_mismatch) begin
			cause_d[`RSC_BIT_CFGMM] = 1'b1;
		end
		if (i_master_clear_pin) begin
			cause_d[`RSC_BIT_PIN] = 1'b1;
		end
		if (i_reset_instruction) begin
			cause_d[`RSC_BIT_SOFT] = 1'b1;
		end
		if (i_watchdog_timeout) begin
			cause_d[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
		end
		if (i_power_save_sleep) begin
			cause_d[`RSC_BIT_SLEEP] = 1'b1;
		end
		if (i_power_save_idle) begin
			cause_d[`RSC_BIT_IDLE] = 1'b1;
		end
		if (i_brown_out_reset) begin
			cause_d[`RSC_BIT_BOR] = 1'b1;
		end
	end

	always @(posedge i_clock) begin
		if (i_rst) begin
			state_q <= ST_POR;
			cause_q <= `RSC_CAUSE_POR_VAL;
			bor_seen_q <= 1'b1;
			o_master_system_reset <= 1'b1;
			o_reset_oscillator_select <= 3'h0;
		end else begin
			state_q <= state_d;
			// flags survive non-power-on resets untouched
			cause_q <= cause_d;
			// held while any source stays active too
			o_master_system_reset <= (state_d != ST_RUN) | any_source;
			if (i_brown_out_reset) begin
				bor_seen_q <= 1'b1;
			end else if (state_q == ST_RUN) begin
				bor_seen_q <= 1'b0;
			end
			// oscillator chosen as reset releases
			if (state_q != ST_RUN && state_d == ST_RUN) begin
				if (~i_clock_switch_enable | bor_seen_q) begin
					o_reset_oscillator_select <= i_initial_oscillator_select;
				end else begin
					o_reset_oscillator_select <= i_current_oscillator_select;
				end
			end
		end
	end

	// derived control outputs follow the stored bits one cycle later
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_watchdog_enable <= 1'b0;
			o_flash_sleep_power <= 1'b0;
		end else begin
			// fuse left unprogrammed forces the watchdog on
			o_watchdog_enable <= i_watchdog_fuse_enable | cause_q[`RSC_BIT_SOFT_WATCHDOG_ENABLE];
			o_flash_sleep_power <= cause_q[`RSC_BIT_FLASHSLP];
		end
	end

	// apb: zero wait states, read data registered in setup cycle
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_prdata <= 32'h0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel & ~i_penable;
			o_pslverr <= i_psel & ~i_penable & ~addr_hit(i_paddr, `RSC_ADDR_CAUSE) &
				~addr_hit(i_paddr, `RSC_ADDR_STATUS) & ~addr_hit(i_paddr, `RSC_ADDR_CLOCK);
			if (rd_en) begin
				if (addr_hit(i_paddr, `RSC_ADDR_CAUSE)) begin
					o_prdata <= {16'h0, cause_q};
				end else if (addr_hit(i_paddr, `RSC_ADDR_STATUS)) begin
					o_prdata <= {28'h0, o_watchdog_enable, bor_seen_q, state_q};
				end else if (addr_hit(i_paddr, `RSC_ADDR_CLOCK)) begin
					o_prdata <= {29'h0, o_reset_oscillator_select};
				end else begin
					o_prdata <= 32'h0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/rsc_source_model.sv ====
`default_nettype none
module rsc_source_model (
	// clock
	input wire logic i_clock,
	// raise one requester for a count of cycles
	input wire logic i_fire,
	input wire logic [2:0] i_sel,
	input wire logic [3:0] i_len,
	// requester lines
	output logic [7:0] o_src
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] left_q = 4'h0;
	logic [2:0] sel_q = 3'h0;
	always @(posedge i_clock) begin
		if (i_fire) begin
			left_q <= i_len;
			sel_q <= i_sel;
		end else if (left_q != 4'h0)
			left_q <= left_q - 4'h1;
	end
	// long counts model a slow requester that holds its line
	assign o_src = (left_q != 4'h0) ? (8'h01 << sel_q) : 8'h00;
endmodule
`default_nettype wire

// ==== test/rsc_checker_sva.sv ====
`default_nettype none
module rsc_checker (
	// clock and power-on
	input wire logic i_clock,
	input wire logic i_rst,
	// requesters
	input wire logic i_brown_out_reset,
	input wire logic i_master_clear_pin,
	input wire logic i_reset_instruction,
	input wire logic i_watchdog_timeout,
	input wire logic i_config_mismatch,
	input wire logic i_trap_conflict,
	input wire logic i_illegal_opcode,
	input wire logic i_uninit_pointer_reset,
	// apb
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// watchdog fuse and outputs
	input wire logic i_watchdog_fuse_enable,
	input wire logic o_watchdog_enable,
	input wire logic o_master_system_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic any_src = i_brown_out_reset | i_master_clear_pin | i_reset_instruction
		| i_watchdog_timeout | i_config_mismatch | i_trap_conflict | i_illegal_opcode
		| i_uninit_pointer_reset;
	wire logic mapped = (i_paddr == 12'h000) | (i_paddr == 12'h004) | (i_paddr == 12'h008);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	chk_src_raises: assert property (any_src |=> o_master_system_reset [*2])
		else $error("system reset not held after a request");
	chk_release_quiet: assert property ($fell(o_master_system_reset) |->
		!$past(any_src) && !$past(any_src, 2))
		else $error("system reset released too soon after a request");
	chk_por_hold: assert property ($fell(i_rst) |-> o_master_system_reset [*8])
		else $error("system reset released before power-up delays");
	chk_apb_ready: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no ready in access cycle");
	chk_ready_once: assert property (o_pready |=> !o_pready)
		else $error("ready held too long");
	chk_addr_decode: assert property (o_pready |-> o_pslverr == !mapped)
		else $error("error response wrong for address");
	chk_unmapped_zero: assert property (o_pready && !i_pwrite && !mapped |-> o_prdata == 32'h0)
		else $error("unmapped read data not zero");
	chk_fuse_wdt: assert property (i_watchdog_fuse_enable |=> o_watchdog_enable)
		else $error("fuse did not force watchdog on");
endmodule
bind rsc_reset_source_combiner rsc_checker rsc_checker_i (.*);
`default_nettype wire

// ==== test/rsc_reset_source_combiner_bench.sv ====
`default_nettype none
module rsc_reset_source_combiner_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic i_power_save_sleep = 1'b0, i_power_save_idle = 1'b0, i_watchdog_clear_instruction = 1'b0;
	logic i_watchdog_fuse_enable = 1'b0, i_clock_switch_enable = 1'b0, fire = 1'b0;
	logic [2:0] i_initial_oscillator_select = 3'h0, i_current_oscillator_select = 3'h0;
	logic [2:0] sel = 3'h0, o_reset_oscillator_select;
	logic [3:0] len = 4'h1;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0, o_prdata, rd, d;
	logic o_pready, o_pslverr, o_master_system_reset, o_watchdog_enable, o_flash_sleep_power, er;
	wire logic [7:0] src;
	wire logic i_brown_out_reset, i_master_clear_pin, i_reset_instruction, i_watchdog_timeout;
	wire logic i_config_mismatch, i_trap_conflict, i_illegal_opcode, i_uninit_pointer_reset;
	int miscompares = 0, compares = 0, k;
	assign {i_uninit_pointer_reset, i_illegal_opcode, i_trap_conflict, i_config_mismatch,
		i_watchdog_timeout, i_reset_instruction, i_master_clear_pin, i_brown_out_reset} = src;
	always #2 i_clock = ~i_clock;
	// short delays keep each release within a few dozen cycles
	rsc_reset_source_combiner #(.TPOR_CYCLES(4), .TPWRT_CYCLES(8), .TRST_CYCLES(2))
		rsc_reset_source_combiner_i (.*);
	rsc_source_model rsc_source_model_i (.i_clock(i_clock), .i_fire(fire), .i_sel(sel),
		.i_len(len), .o_src(src));
	function automatic int pos(int n);
		case (n)
			0: pos = 1;
			1: pos = 7;
			2: pos = 6;
			3: pos = 4;
			4: pos = 9;
			5: pos = 15;
			default: pos = 14;
		endcase
	endfunction
	task conclude();
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= wd;
		@(posedge i_clock);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_pready !== 1'b1 && n < 50);
		if (o_pready !== 1'b1)
			miscompares++;
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task wrel();
		int n;
		n = 0;
		repeat (3) @(posedge i_clock);
		while (o_master_system_reset !== 1'b0 && n < 300) begin
			@(posedge i_clock);
			n++;
		end
		if (o_master_system_reset !== 1'b0)
			miscompares++;
	endtask
	initial begin
		k = $urandom(32'h78dd);
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		wrel();
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h3);
		for (k = 0; k < 8; k++) begin
			apb(1'b1, 12'h000, 32'h0);
			i_clock_switch_enable <= 1'($urandom);
			i_initial_oscillator_select <= 3'($urandom);
			i_current_oscillator_select <= 3'($urandom);
			i_watchdog_fuse_enable <= 1'($urandom);
			sel <= k[2:0];
			len <= 4'h1 + 4'($urandom % 4);
			fire <= 1'b1;
			@(posedge i_clock);
			fire <= 1'b0;
			wrel();
			apb(1'b0, 12'h000, 32'h0);
			chk(rd, 32'h1 << pos(k));
			d = (k == 0 || !i_clock_switch_enable) ? 32'(i_initial_oscillator_select)
				: 32'(i_current_oscillator_select);
			chk(32'(o_reset_oscillator_select), d);
			apb(1'b0, 12'h008, 32'h0);
			chk(rd, d);
		end
		d = $urandom;
		i_watchdog_fuse_enable <= 1'b0;
		apb(1'b1, 12'h000, d);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, d & 32'h0000c3ff);
		chk(32'(o_master_system_reset), 32'h0);
		chk(32'(o_flash_sleep_power), 32'(d[8]));
		chk(32'(o_watchdog_enable), 32'(d[5]));
		apb(1'b1, 12'h000, 32'h10);
		i_power_save_sleep <= 1'b1;
		@(posedge i_clock);
		i_power_save_sleep <= 1'b0;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h8);
		apb(1'b1, 12'h000, 32'h18);
		i_watchdog_clear_instruction <= 1'b1;
		@(posedge i_clock);
		i_watchdog_clear_instruction <= 1'b0;
		i_power_save_idle <= 1'b1;
		@(posedge i_clock);
		i_power_save_idle <= 1'b0;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'hc);
		apb(1'b1, 12'h00c, 32'hffffffff);
		chk(32'(er), 32'h1);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h0);
		chk(32'(er), 32'h1);
		i_rst <= 1'b1;
		@(posedge i_clock);
		i_rst <= 1'b0;
		wrel();
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h3);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'(i_initial_oscillator_select));
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h3);
		conclude();
	end
	initial begin
		repeat (5000) @(posedge i_clock);
		miscompares++;
		conclude();
	end
endmodule
`default_nettype wire
